// ### framer_model.sv
module framer_model
   import liu_diag_pkg::*;
#(
   parameter int HALF_NS  = 12,
   parameter int PHASE_NS = 0
)
(
   input  wire liu_diag_pkg::rail_pair_t word,
   output      logic                     tx_clk,
   output      liu_diag_pkg::rail_pair_t tx_data
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      tx_clk  = 1'b0;
      tx_data = 2'h0;
      // Line clock runs free, framers never stop it
      #PHASE_NS;
      forever #HALF_NS tx_clk = ~tx_clk;
   end

   // Data moves on the falling edge, clear of the sampling edge
   always @(negedge tx_clk) tx_data <= word;
endmodule

// ### liu_channel_diagnostics.sv
// Overview of operation
// R1 - Sequence test only under host control
// R2 - Send 2^23-1 at E3, else 2^15-1
// R3 - Enabling generator also enables receive checker
// R4 - Locked checker drives violation output low
// R5 - Unlocked: loss flag set, output high
// R6 - Writing one inserts exactly one error
// R7 - Software writes zero before next insert
// R8 - Each detected error pulses output once
// R9 - Sequence mode forces single-rail operation
// R10 - Loopback from pins or host bits
// R11 - Analog loop: line out feeds receiver
// R12 - Analog loop keeps line outputs driven
// R13 - Analog loop ignores line receive inputs
// R14 - Digital loop returns terminal clock, data
// R15 - Remote loop sends receive data back
// R16 - Remote loop through attenuator, recovered clock (no attenuator here: receive data is only reclocked on receive_timing_clock)
// R17 - Remote loop ignores terminal transmit inputs
// R18 - All-ones from pin or host bit
// R19 - All-ones sends alternating marks on line
// R20 - All-ones inactive in analog, remote loops
// R21 - Loopback resolved before all-ones substitution
module liu_channel_diagnostics
   import liu_diag_pkg::*;
(
   input  wire logic                    ref_clk,
   input  wire logic                    rst_b,
   input  wire logic                    clk_en,
   input  wire liu_diag_pkg::chan_ctrl_t ctrl,
   input  wire liu_diag_pkg::hw_pins_t  hw_pins,
   input  wire logic                    terminal_tx_clock,
   input  wire liu_diag_pkg::rail_pair_t terminal_tx_data,
   input  wire logic                    receive_timing_clock,
   input  wire liu_diag_pkg::rail_pair_t line_rx_data,
   output      liu_diag_pkg::rail_pair_t line_tx_data,
   output      logic                    transmit_timing_clock,
   output      logic                    rx_clk_out,
   output      logic                    rx_pos_data_out,
   output      logic                    rx_neg_violation_out,
   output      logic                    prbs_sync_loss_flag,
   output      liu_diag_pkg::loop_mode_t loop_mode
);
   import liu_diag_pkg::*;

   // Control synchronisers into the transmit domain
   chan_ctrl_t ctl_s1_q;
   chan_ctrl_t ctl_s2_q;
   hw_pins_t   pin_s1_q;
   hw_pins_t   pin_s2_q;
   // Control synchronisers into the receive domain
   chan_ctrl_t rctl_s1_q;
   chan_ctrl_t rctl_s2_q;
   hw_pins_t   rpin_s1_q;
   hw_pins_t   rpin_s2_q;

   loop_mode_t tx_loop;
   loop_mode_t rx_loop;
   logic       tx_prbs_on;
   logic       rx_prbs_on;
   logic       tx_all_ones;

   logic [PRBS_W-1:0] gen_q;
   logic              ins_prev_q;
   logic              ins_pend_q;
   logic              mark_q;
   rail_pair_t        tx_out_q;
   logic              gen_fb;
   logic              gen_bit;

   logic [PRBS_W-1:0] chk_q;
   logic [SYNC_CNT_W-1:0] good_cnt_q;
   logic [SYNC_CNT_W-1:0] win_cnt_q;
   logic [SYNC_CNT_W-1:0] bad_cnt_q;
   logic              locked_q;
   logic              err_q;
   logic              loss_s1_q;
   logic              loss_s2_q;
   logic              en_s1_q;
   logic              en_s2_q;
   logic              rx_bit;
   logic              chk_pred;
   rail_pair_t        rx_q;
   rail_pair_t        loop_rx;

   function automatic logic prbs_fb(input logic [PRBS_W-1:0] s, input logic e3);
      if (e3)
         return s[PRBS_LEN_E3-1] ^ s[PRBS_TAP_E3-1];
      return s[PRBS_LEN_DS3-1] ^ s[PRBS_TAP_DS3-1];
   endfunction

   always_ff @(posedge terminal_tx_clock)
   begin
      ctl_s1_q <= ctrl;
      ctl_s2_q <= ctl_s1_q;
      pin_s1_q <= hw_pins;
      pin_s2_q <= pin_s1_q;
   end

   always_ff @(posedge receive_timing_clock)
   begin
      rctl_s1_q <= ctrl;
      rctl_s2_q <= rctl_s1_q;
      rpin_s1_q <= hw_pins;
      rpin_s2_q <= rpin_s1_q;
   end

   // Pins in hardware mode, host bits otherwise
   assign tx_loop = ctl_s2_q.host_mode ?                                          // R10
      decode_loop(ctl_s2_q.remote_loop_bit, ctl_s2_q.local_loop_bit) :
      decode_loop(pin_s2_q.remote_loop_select, pin_s2_q.local_loop_select);
   assign rx_loop = rctl_s2_q.host_mode ?                                         // R10
      decode_loop(rctl_s2_q.remote_loop_bit, rctl_s2_q.local_loop_bit) :
      decode_loop(rpin_s2_q.remote_loop_select, rpin_s2_q.local_loop_select);
   assign tx_prbs_on = ctl_s2_q.host_mode & ctl_s2_q.prbs_enable_bit;             // R1
   assign rx_prbs_on = rctl_s2_q.host_mode & rctl_s2_q.prbs_enable_bit;           // R1 R3
   assign tx_all_ones = (ctl_s2_q.host_mode ? ctl_s2_q.all_ones_bit :             // R18
      pin_s2_q.all_ones_request) &
      (tx_loop != LOOP_ANALOG) & (tx_loop != LOOP_REMOTE);                        // R20 R21
   assign loop_mode = tx_loop;

   // Generator
   assign gen_fb  = prbs_fb(gen_q, ctl_s2_q.e3_rate);                              // R2
   assign gen_bit = gen_fb ^ ins_pend_q;                                          // R6

   always_ff @(posedge terminal_tx_clock)
   begin
      if (!rst_b || !tx_prbs_on)
         gen_q <= PRBS_SEED;
      else
         gen_q <= {gen_q[PRBS_W-2:0], gen_fb};                                    // R2
   end

   // Edge of the insert bit arms one error; clearing it rearms
   always_ff @(posedge terminal_tx_clock)
   begin
      if (!rst_b)
      begin
         ins_prev_q <= 1'b0;
         ins_pend_q <= 1'b0;
      end
      else
      begin
         ins_prev_q <= ctl_s2_q.prbs_error_insert_bit;                            // R7
         if (tx_prbs_on && ctl_s2_q.prbs_error_insert_bit && !ins_prev_q)
            ins_pend_q <= 1'b1;                                                   // R6
         else
            ins_pend_q <= 1'b0;
      end
   end

   // Line transmit rails; data path on the terminal transmit clock outside remote loop
   always_ff @(posedge terminal_tx_clock)
   begin
      if (!rst_b)
      begin
         mark_q   <= 1'b0;
         tx_out_q <= '0;
      end
      else if (tx_all_ones)
      begin
         mark_q   <= ~mark_q;
         tx_out_q <= {~mark_q, mark_q};                                           // R19
      end
      else if (tx_prbs_on)
      begin
         tx_out_q <= {gen_bit, 1'b0};                                             // R9
      end
      else if (ctl_s2_q.single_rail_cfg)
      begin
         tx_out_q <= {terminal_tx_data.pos, 1'b0};
      end
      else
      begin
         tx_out_q <= terminal_tx_data;
      end
   end

   // Remote loop reclocks receive data on recovered timing, terminal ignored
   rail_pair_t rem_q;
   always_ff @(posedge receive_timing_clock)
   begin
      if (!rst_b)
         rem_q <= '0;
      else
         rem_q <= line_rx_data;                                                   // R15 R16
   end

   assign line_tx_data = (tx_loop == LOOP_REMOTE) ? rem_q : tx_out_q;             // R12 R15 R17
   assign transmit_timing_clock = (tx_loop == LOOP_REMOTE) ?                      // R16
      receive_timing_clock : terminal_tx_clock;

   // Receiver source selection; analog loop drops the line inputs
   assign loop_rx = (rx_loop == LOOP_ANALOG) ? line_tx_data : line_rx_data;       // R11 R13
   assign rx_clk_out = (rx_loop == LOOP_DIGITAL) ? terminal_tx_clock :            // R14
      (rx_loop == LOOP_ANALOG) ? transmit_timing_clock : receive_timing_clock;    // R11

   always_ff @(posedge receive_timing_clock)
   begin
      if (!rst_b)
         rx_q <= '0;
      else
         rx_q <= loop_rx;
   end

   // Checker: self-synchronising, seeded from received bits
   assign rx_bit   = rx_q.pos;
   assign chk_pred = prbs_fb(chk_q, rctl_s2_q.e3_rate);

   always_ff @(posedge receive_timing_clock)
   begin
      if (!rst_b || !rx_prbs_on)
         chk_q <= '0;
      else
         chk_q <= {chk_q[PRBS_W-2:0], rx_bit};
   end

   always_ff @(posedge receive_timing_clock)
   begin
      if (!rst_b || !rx_prbs_on)
      begin
         good_cnt_q <= '0;
         win_cnt_q  <= '0;
         bad_cnt_q  <= '0;
         locked_q   <= 1'b0;
         err_q      <= 1'b0;
      end
      else if (!locked_q)
      begin
         err_q <= 1'b0;
         if (chk_pred != rx_bit)
            good_cnt_q <= '0;
         else if (good_cnt_q == SYNC_CNT_W'(SYNC_LOCK_CNT - 1))
         begin
            locked_q   <= 1'b1;                                                   // R4
            good_cnt_q <= '0;
            win_cnt_q  <= '0;
            bad_cnt_q  <= '0;
         end
         else
            good_cnt_q <= good_cnt_q + 1'b1;
      end
      else
      begin
         err_q     <= (chk_pred != rx_bit);                                       // R8
         win_cnt_q <= win_cnt_q + 1'b1;
         // Too many errors in one window means lost alignment
         if (win_cnt_q == SYNC_CNT_W'(ERR_WIN - 1))
            bad_cnt_q <= '0;
         else if (chk_pred != rx_bit)
         begin
            if (bad_cnt_q == SYNC_CNT_W'(SYNC_LOSS_ERRS - 1))
               locked_q <= 1'b0;                                                  // R5
            bad_cnt_q <= bad_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge receive_timing_clock)
   begin
      if (!rst_b)
      begin
         rx_pos_data_out      <= 1'b0;
         rx_neg_violation_out <= 1'b0;
      end
      else if (rx_prbs_on)
      begin
         rx_pos_data_out      <= rx_q.pos;
         rx_neg_violation_out <= ~locked_q | err_q;                               // R4 R5 R8
      end
      else
      begin
         rx_pos_data_out      <= (rx_loop == LOOP_DIGITAL) ? terminal_tx_data.pos : rx_q.pos;
         rx_neg_violation_out <= (rx_loop == LOOP_DIGITAL) ? terminal_tx_data.neg : rx_q.neg;
      end
   end

   // Status flag crosses to the register clock
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         loss_s1_q           <= 1'b1;
         loss_s2_q           <= 1'b1;
         en_s1_q             <= 1'b0;
         en_s2_q             <= 1'b0;
         prbs_sync_loss_flag <= 1'b0;
      end
      else if (clk_en)
      begin
         loss_s1_q           <= ~locked_q;
         loss_s2_q           <= loss_s1_q;
         // Control levels are asynchronous here too
         en_s1_q             <= ctrl.host_mode & ctrl.prbs_enable_bit;
         en_s2_q             <= en_s1_q;
         prbs_sync_loss_flag <= loss_s2_q & en_s2_q;                              // R5
      end
   end

   sequence s_locked_err;
      rx_prbs_on && locked_q && err_q;
   endsequence

   sequence s_ins_rise;
      tx_prbs_on && ctl_s2_q.prbs_error_insert_bit && !ins_prev_q;
   endsequence

   sequence s_ins_held;
      ctl_s2_q.prbs_error_insert_bit && ins_prev_q;
   endsequence

   property p_err_pulse;
      @(posedge receive_timing_clock) disable iff (!rst_b)
      s_locked_err |=> rx_neg_violation_out;
   endproperty

   property p_ins_arm;
      @(posedge terminal_tx_clock) disable iff (!rst_b)
      s_ins_rise |=> ins_pend_q;
   endproperty

   property p_ins_held;
      @(posedge terminal_tx_clock) disable iff (!rst_b)
      s_ins_held |=> !ins_pend_q;
   endproperty

   AST_ERR_PULSE: assert property (p_err_pulse) // R8
      else $error("error pulse missing on violation output");

   AST_INS_ARM: assert property (p_ins_arm) // R6
      else $error("insert edge did not arm an error");

   AST_INS_HELD: assert property (p_ins_held) // R7
      else $error("held insert bit armed another error");

   AST_AMI_RAILS: assert property (@(posedge terminal_tx_clock) disable iff (!rst_b) // R19
      tx_all_ones |=> (tx_out_q.neg == !tx_out_q.pos))
      else $error("all-ones mark not on exactly one rail");

   AST_SEED_IDLE: assert property (@(posedge terminal_tx_clock) disable iff (!rst_b) // R1
      !tx_prbs_on |=> (gen_q == PRBS_SEED))
      else $error("generator running without sequence mode");

   AST_ANALOG_RX: assert property (@(posedge receive_timing_clock) disable iff (!rst_b) // R13
      (rx_loop == LOOP_ANALOG) |=> (rx_q == $past(line_tx_data)))
      else $error("analog loop not fed from line outputs");

   AST_DIG_DATA: assert property (@(posedge receive_timing_clock) disable iff (!rst_b) // R14
      (!rx_prbs_on && rx_loop == LOOP_DIGITAL)
      |=> (rx_pos_data_out == $past(terminal_tx_data.pos)))
      else $error("digital loop data not returned");

   AST_LOCK_LOW: assert property (@(posedge receive_timing_clock) disable iff (!rst_b) // R4
      (rx_prbs_on && locked_q && !err_q) |=> !rx_neg_violation_out)
      else $error("violation output high while locked");
   AST_LOSS_HIGH: assert property (@(posedge receive_timing_clock) disable iff (!rst_b) // R5
      (rx_prbs_on && !locked_q) |=> rx_neg_violation_out)
      else $error("violation output low while unlocked");
   AST_ONE_ERR: assert property (@(posedge terminal_tx_clock) disable iff (!rst_b) // R6
      ins_pend_q |=> !ins_pend_q)
      else $error("more than one error inserted");
   AST_SINGLE_RAIL: assert property (@(posedge terminal_tx_clock) disable iff (!rst_b) // R9
      (tx_prbs_on && !tx_all_ones && tx_loop != LOOP_REMOTE) |=> !line_tx_data.neg)
      else $error("negative rail active in sequence mode");
   AST_NO_HW_PRBS: assert property (@(posedge terminal_tx_clock) disable iff (!rst_b) // R1
      !ctl_s2_q.host_mode |-> !tx_prbs_on)
      else $error("sequence active in hardware mode");
   AST_AIS_BLOCK: assert property (@(posedge terminal_tx_clock) disable iff (!rst_b) // R20
      (tx_loop == LOOP_ANALOG || tx_loop == LOOP_REMOTE) |-> !tx_all_ones)
      else $error("all-ones active in analog or remote loop");
   AST_AMI: assert property (@(posedge terminal_tx_clock) disable iff (!rst_b) // R19
      (tx_all_ones && $past(tx_all_ones)) |=> (tx_out_q.pos != $past(tx_out_q.pos)))
      else $error("all-ones marks not alternating");
   AST_REMOTE: assert property (@(posedge receive_timing_clock) disable iff (!rst_b) // R17
      (rx_loop == LOOP_REMOTE && tx_loop == LOOP_REMOTE) |-> line_tx_data == rem_q)
      else $error("remote loop not returning receive data");
endmodule

// ### liu_diag_pkg.sv
package liu_diag_pkg;

   // Pattern lengths
   localparam int PRBS_LEN_E3      = 23;
   localparam int PRBS_LEN_DS3     = 15;
   localparam int PRBS_TAP_E3      = 18;
   localparam int PRBS_TAP_DS3     = 14;
   localparam int PRBS_W           = 23;
   localparam logic [PRBS_W-1:0] PRBS_SEED = 23'h7FFFFF;
   // Checker lock and loss thresholds
   localparam int SYNC_LOCK_CNT    = 32;
   localparam int SYNC_LOSS_ERRS   = 6;
   localparam int SYNC_CNT_W       = 6;
   localparam int ERR_WIN          = 32;

   typedef enum logic [1:0] {
      LOOP_NONE,
      LOOP_ANALOG,
      LOOP_REMOTE,
      LOOP_DIGITAL
   } loop_mode_t;

   typedef struct packed {
      logic host_mode;
      logic prbs_enable_bit;
      logic prbs_error_insert_bit;
      logic e3_rate;
      logic single_rail_cfg;
      logic remote_loop_bit;
      logic local_loop_bit;
      logic all_ones_bit;
   } chan_ctrl_t;

   typedef struct packed {
      logic remote_loop_select;
      logic local_loop_select;
      logic all_ones_request;
   } hw_pins_t;

   typedef struct packed {
      logic pos;
      logic neg;
   } rail_pair_t;

   function automatic loop_mode_t decode_loop(input logic rlb, input logic llb);
      loop_mode_t m;
      m = LOOP_NONE;
      if (rlb && llb)
         m = LOOP_REMOTE;
      else if (!rlb && llb)
         m = LOOP_ANALOG;
      else if (rlb && !llb)
         m = LOOP_DIGITAL;
      return m;
   endfunction

endpackage

// ### tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import liu_diag_pkg::*;

   typedef struct packed {
      logic       host;
      logic [1:0] sel;
      loop_mode_t exp;
   } row_t;

   logic        ref_clk;
   logic        rst_b;
   logic        rx_clk;
   chan_ctrl_t  ctrl;
   hw_pins_t    pins;
   rail_pair_t  word;
   rail_pair_t  line_rx;
   logic        tx_clk;
   rail_pair_t  tx_data;
   rail_pair_t  line_tx;
   logic        tt_clk;
   logic        rx_clk_o;
   logic        rx_pos;
   logic        rx_viol;
   logic        loss;
   loop_mode_t  lmode;
   logic [31:0] sr;
   logic [31:0] first_sr;
   int          err_count;
   int          n_tests;
   row_t        rows [8] = '{'{1'b0, 2'h0, LOOP_NONE}, '{1'b0, 2'h1, LOOP_ANALOG},
                             '{1'b0, 2'h2, LOOP_DIGITAL}, '{1'b0, 2'h3, LOOP_REMOTE},
                             '{1'b1, 2'h0, LOOP_NONE}, '{1'b1, 2'h1, LOOP_ANALOG},
                             '{1'b1, 2'h2, LOOP_DIGITAL}, '{1'b1, 2'h3, LOOP_REMOTE}};

   always #10 ref_clk = ~ref_clk;
   always #15 rx_clk = ~rx_clk;

   // Same rate as the receive clock so analog loop keeps every bit
   framer_model #(.HALF_NS(15), .PHASE_NS(7)) u_framer (
      .word(word), .tx_clk(tx_clk), .tx_data(tx_data));

   liu_channel_diagnostics DUT (
      .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1), .ctrl(ctrl), .hw_pins(pins),
      .terminal_tx_clock(tx_clk), .terminal_tx_data(tx_data),
      .receive_timing_clock(rx_clk), .line_rx_data(line_rx), .line_tx_data(line_tx),
      .transmit_timing_clock(tt_clk), .rx_clk_out(rx_clk_o), .rx_pos_data_out(rx_pos),
      .rx_neg_violation_out(rx_viol), .prbs_sync_loss_flag(loss), .loop_mode(lmode));

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task close_out;
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask

   task ami;
      logic p;
      cyc(6);
      @(negedge tx_clk);
      p = line_tx.pos;
      repeat (6)
      begin
         @(negedge tx_clk);
         chk("ami", 32'({~p, p}), 32'(line_tx));
         p = line_tx.pos;
      end
   endtask

   task wait_lock;
      int i;
      i = 0;
      while (rx_viol !== 1'b0 && i < 400)
      begin
         @(negedge rx_clk);
         i++;
      end
      if (i == 400)
      begin
         err_count++;
         $display("mismatch lock expected 0 seen 1");
         close_out();
      end
   endtask

   task grab(input int n);
      repeat (n)
      begin
         @(negedge tx_clk);
         sr = {sr[30:0], line_tx.pos};
      end
   endtask

   // Second window with the bit still high must stay quiet
   task ins;
      int n;
      int m;
      n = 0;
      m = 0;
      cyc(1);
      ctrl.prbs_error_insert_bit = 1'b1;
      repeat (40) @(negedge rx_clk) n += int'(rx_viol === 1'b1);
      repeat (40) @(negedge rx_clk) m += int'(rx_viol === 1'b1);
      cyc(1);
      ctrl.prbs_error_insert_bit = 1'b0;
      cyc(10);
      chk("err pulses", 32'h1, 32'(n >= 1 && n <= 3));
      chk("held insert", 32'h0, 32'(m));
   endtask

   initial
   begin
      ref_clk   = 1'b0;
      rx_clk    = 1'b0;
      rst_b     = 1'b0;
      ctrl      = 8'h0;
      pins      = 3'h0;
      word      = 2'h0;
      line_rx   = 2'h0;
      sr        = 32'h0;
      err_count = 0;
      n_tests   = 0;
      repeat (6) @(negedge ref_clk);
      chk("reset viol", 32'h0, 32'(rx_viol));
      chk("reset loss", 32'h0, 32'(loss));
      rst_b = 1'b1;
      cyc(4);
      // Unused source set opposite, so a wrong pick shows
      foreach (rows[i])
      begin
         ctrl.host_mode = rows[i].host;
         {ctrl.remote_loop_bit, ctrl.local_loop_bit} = rows[i].host ? rows[i].sel : ~rows[i].sel;
         {pins.remote_loop_select, pins.local_loop_select} = rows[i].host ? ~rows[i].sel : rows[i].sel;
         cyc(10);
         chk("loop_mode", 32'(rows[i].exp), 32'(lmode));
      end
      ctrl = 8'h0;
      pins = 3'h5;
      word = 2'h2;
      line_rx = 2'h1;
      cyc(12);
      @(posedge tx_clk);
      #1 chk("dig clk", 32'(tx_clk), 32'(rx_clk_o));
      chk("dig data", 32'h1, 32'(rx_pos));
      ami();
      pins = 3'h3;
      cyc(12);
      chk("ana line", 32'h2, 32'(line_tx));
      chk("ana data", 32'h1, 32'(rx_pos));
      pins = 3'h7;
      word = 2'h1;
      line_rx = 2'h2;
      cyc(12);
      chk("rem line", 32'h2, 32'(line_tx));
      chk("rem data", 32'h1, 32'(rx_pos));
      @(posedge rx_clk);
      #1 chk("rem clk", 32'(rx_clk), 32'(tt_clk));
      pins = 3'h1;
      ami();
      ctrl.host_mode = 1'b1;
      ctrl.all_ones_bit = 1'b1;
      pins = 3'h0;
      ami();
      ctrl = 8'h0;
      ctrl.prbs_enable_bit = 1'b1;
      word = 2'h2;
      cyc(60);
      chk("hw seq loss", 32'h0, 32'(loss));
      chk("hw seq line", 32'h2, 32'(line_tx));
      // Analog loop feeds the checker its own sequence
      ctrl.host_mode = 1'b1;
      ctrl.local_loop_bit = 1'b1;
      cyc(8);
      chk("unlocked loss", 32'h1, 32'(loss));
      chk("unlocked viol", 32'h1, 32'(rx_viol));
      wait_lock();
      chk("locked viol", 32'h0, 32'(rx_viol));
      cyc(4);
      chk("locked loss", 32'h0, 32'(loss));
      grab(32);
      chk("single rail", 32'h0, 32'(line_tx.neg));
      first_sr = sr;
      grab(32767);
      chk("period", first_sr, sr);
      ins();
      ins();
      close_out();
   end
endmodule
